// ==== core/fault_flag_pkg.sv ====
// Package of register indices, field positions and reset values for the fault flag readback block.
// Assumes a 32-bit AXI4-Lite slave; byte address of each register is four times its index.
package fault_flag_pkg;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] IDX_SOURCE_MASK = 8'h1D;
  localparam logic [7:0] IDX_LIVE = 8'h22;
  localparam logic [7:0] IDX_LATCH_LIMITER = 8'h24;
  localparam logic [7:0] IDX_LATCH_DIAG = 8'h25;
  localparam logic [7:0] IDX_LATCH_CLOCK = 8'h26;
  localparam logic [7:0] IDX_INT_CLK_CFG = 8'h30;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'h19;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LIVE_POWER_DOWN_BIT = 7;
  localparam int LIVE_MIC_CLK_BIT = 4;
  localparam int LIVE_SERIAL2_CLK_BIT = 3;
  localparam int DIAG_DONE_BIT = 5;
  localparam int DIAG_FAULT_LSB = 3;
  localparam int BROWNOUT_LSB = 0;
  localparam int BROWNOUT_W = 3;
  localparam int CFG_CLEAR_BIT = 2;
  localparam int REG_W = 8;
  localparam int IDX_LSB = 2;

  // Load diagnostic result codes
  localparam logic [1:0] DIAG_NORMAL = 2'h0;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_SHORT = 2'h2;

  // ****************************************
  // AXI responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fault_flag_pkg

// ==== core/fault_event_flag_readback.sv ====
// Live and sticky fault/event flag readback with mask and latch-clear control over AXI4-Lite.
// Assumes all event inputs come from other domains and are held at least two clock cycles.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

module fault_event_flag_readback #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Live event sources
  input wire logic power_down_in,
  input wire logic mic_clk_err_in,
  input wire logic serial2_clk_err_in,
  // Latched event sources
  input wire logic [7:0] limiter_fault_src,
  input wire logic load_diag_done_in,
  input wire logic [1:0] load_diag_fault_in,
  input wire logic [2:0] brownout_src,
  input wire logic [7:0] clock_supply_src,
  // Control outputs to the interrupt pin logic
  output logic [7:0] source_mask,
  output logic [7:0] int_clk_cfg
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = 25;
  logic [SYNC_W-1:0] sync_meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic pd_s;
  logic mic_s;
  logic ser2_s;
  logic [7:0] lim_s;
  logic diag_done_s;
  logic [1:0] diag_fault_s;
  logic [2:0] brown_s;
  logic [7:0] clk_s;

  // Two flops per source; the first flop is read by the second only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      sync_meta_reg <= {power_down_in, mic_clk_err_in, serial2_clk_err_in, limiter_fault_src,
                        load_diag_done_in, load_diag_fault_in, brownout_src, clock_supply_src};
      sync_reg <= sync_meta_reg;
    end
  end

  assign {pd_s, mic_s, ser2_s, lim_s, diag_done_s, diag_fault_s, brown_s, clk_s} = sync_reg;

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_do;
  logic [ADDR_W-3:0] widx;
  logic w_map;

  // Accept address and data separately; stall both while a response waits
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
  assign widx = waddr_reg[ADDR_W-1:fault_flag_pkg::IDX_LSB];
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // Write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Writes to the readback registers are ignored but answered OKAY, like mask and config writes; unmapped addresses get SLVERR
  always_comb begin
    w_map = 1'b0;
    if (widx == (ADDR_W-2)'(fault_flag_pkg::IDX_LIVE) ||
        widx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_LIMITER) ||
        widx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_DIAG) ||
        widx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_CLOCK) ||
        widx == (ADDR_W-2)'(fault_flag_pkg::IDX_SOURCE_MASK) ||
        widx == (ADDR_W-2)'(fault_flag_pkg::IDX_INT_CLK_CFG)) begin
      w_map = 1'b1;
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= fault_flag_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_map ? fault_flag_pkg::RESP_OKAY : fault_flag_pkg::RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] mask_reg;
  logic [7:0] cfg_reg;
  logic clear_reg;
  logic wr_mask;
  logic wr_cfg;

  assign wr_mask = wr_do && wlane_reg && widx == (ADDR_W-2)'(fault_flag_pkg::IDX_SOURCE_MASK);
  assign wr_cfg = wr_do && wlane_reg && widx == (ADDR_W-2)'(fault_flag_pkg::IDX_INT_CLK_CFG);
  assign source_mask = mask_reg;
  assign int_clk_cfg = cfg_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= fault_flag_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= wbyte_reg;
    end
  end

  // config with self-clearing clear bit; the bit never stores, so it always reads 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= fault_flag_pkg::CFG_RESET;
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= wr_cfg && wbyte_reg[fault_flag_pkg::CFG_CLEAR_BIT];
      if (wr_cfg) begin
        cfg_reg <= wbyte_reg & ~(8'h01 << fault_flag_pkg::CFG_CLEAR_BIT);
      end
    end
  end

  // ****************************************
  // Sticky flags
  // ****************************************
  logic [7:0] lat_lim_reg;
  logic [2:0] lat_brown_reg;
  logic lat_done_reg;
  logic [1:0] lat_fault_reg;
  logic [7:0] lat_clk_reg;

  // a set in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_lim_reg <= fault_flag_pkg::FLAGS_RESET;
    end else begin
      lat_lim_reg <= (clear_reg ? 8'h00 : lat_lim_reg) | lim_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_brown_reg <= 3'h0;
    end else begin
      lat_brown_reg <= (clear_reg ? 3'h0 : lat_brown_reg) | brown_s;
    end
  end

  // completion latch; the result code is captured with completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_done_reg <= 1'b0;
      lat_fault_reg <= fault_flag_pkg::DIAG_NORMAL;
    end else if (diag_done_s) begin
      lat_done_reg <= 1'b1;
      lat_fault_reg <= diag_fault_s;
    end else if (clear_reg) begin
      lat_done_reg <= 1'b0;
      lat_fault_reg <= fault_flag_pkg::DIAG_NORMAL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_clk_reg <= fault_flag_pkg::FLAGS_RESET;
    end else begin
      lat_clk_reg <= (clear_reg ? 8'h00 : lat_clk_reg) | clk_s;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] live_val;
  logic [7:0] diag_val;
  logic [7:0] rd_val;
  logic rd_map;
  logic [ADDR_W-3:0] ridx;

  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign ridx = araddr[ADDR_W-1:fault_flag_pkg::IDX_LSB];

  always_comb begin
    live_val = 8'h00;
    live_val[fault_flag_pkg::LIVE_POWER_DOWN_BIT] = pd_s;
    live_val[fault_flag_pkg::LIVE_MIC_CLK_BIT] = mic_s;
    live_val[fault_flag_pkg::LIVE_SERIAL2_CLK_BIT] = ser2_s;
  end

  always_comb begin
    diag_val = 8'h00;
    diag_val[fault_flag_pkg::DIAG_DONE_BIT] = lat_done_reg;
    diag_val[fault_flag_pkg::DIAG_FAULT_LSB +: 2] = lat_fault_reg;
    diag_val[fault_flag_pkg::BROWNOUT_LSB +: fault_flag_pkg::BROWNOUT_W] = lat_brown_reg;
  end

  // Read decode; unmapped addresses return zero with SLVERR
  always_comb begin
    rd_val = 8'h00;
    rd_map = 1'b1;
    if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_LIVE)) begin
      rd_val = live_val;
    end else if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_LIMITER)) begin
      rd_val = lat_lim_reg;
    end else if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_DIAG)) begin
      rd_val = diag_val;
    end else if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_LATCH_CLOCK)) begin
      rd_val = lat_clk_reg;
    end else if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_SOURCE_MASK)) begin
      rd_val = mask_reg;
    end else if (ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_INT_CLK_CFG)) begin
      rd_val = cfg_reg;
    end else begin
      rd_map = 1'b0;
    end
  end

  // Registered read answer, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= fault_flag_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_val};
      rresp_reg <= rd_map ? fault_flag_pkg::RESP_OKAY : fault_flag_pkg::RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic rd_live;
  logic rd_cfg;
  assign rd_live = arvalid && arready && ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_LIVE);
  assign rd_cfg = arvalid && arready && ridx == (ADDR_W-2)'(fault_flag_pkg::IDX_INT_CLK_CFG);

  property p_live_power_down;
    @(posedge aclk) disable iff (!aresetn) rd_live |=> rvalid && rdata[7] == $past(pd_s);
  endproperty
  a_live_power_down: assert property (p_live_power_down) else $error("power-down live bit wrong");

  property p_live_mic;
    @(posedge aclk) disable iff (!aresetn) rd_live |=> rdata[4] == $past(mic_s);
  endproperty
  a_live_mic: assert property (p_live_mic) else $error("mic clock live bit wrong");

  property p_live_serial2;
    @(posedge aclk) disable iff (!aresetn) rd_live |=> rdata[3] == $past(ser2_s);
  endproperty
  a_live_serial2: assert property (p_live_serial2) else $error("serial port live bit wrong");

  property p_live_reserved;
    @(posedge aclk) disable iff (!aresetn) rd_live |=> rdata[31:8] == 24'h00_0000 && rdata[6:5] == 2'h0
      && rdata[2:0] == 3'h0;
  endproperty
  a_live_reserved: assert property (p_live_reserved) else $error("live reserved bits not zero");

  property p_limiter_sets;
    @(posedge aclk) disable iff (!aresetn) (lim_s != 8'h00) |=> (lat_lim_reg & $past(lim_s)) == $past(lim_s);
  endproperty
  a_limiter_sets: assert property (p_limiter_sets) else $error("limiter flag not latched");

  property p_limiter_holds;
    @(posedge aclk) disable iff (!aresetn) !clear_reg [*2]
      |-> (lat_lim_reg & $past(lat_lim_reg)) == $past(lat_lim_reg);
  endproperty
  a_limiter_holds: assert property (p_limiter_holds) else $error("limiter flag dropped without clear");

  property p_clock_holds;
    @(posedge aclk) disable iff (!aresetn) !clear_reg |=> (lat_clk_reg & $past(lat_clk_reg)) == $past(lat_clk_reg)
      && (lat_clk_reg & $past(clk_s)) == $past(clk_s);
  endproperty
  a_clock_holds: assert property (p_clock_holds) else $error("clock flag not held");

  property p_clear_all;
    @(posedge aclk) disable iff (!aresetn) clear_reg && lim_s == 8'h00 && clk_s == 8'h00 && brown_s == 3'h0
      && !diag_done_s |=> lat_lim_reg == 8'h00 && lat_clk_reg == 8'h00 && lat_brown_reg == 3'h0 && !lat_done_reg;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear left a flag set");

  property p_diag_capture;
    @(posedge aclk) disable iff (!aresetn) diag_done_s |=> lat_done_reg && lat_fault_reg == $past(diag_fault_s);
  endproperty
  a_diag_capture: assert property (p_diag_capture) else $error("diagnostic result not captured");

  property p_cfg_clear_reads_zero;
    @(posedge aclk) disable iff (!aresetn) rd_cfg |=> rdata[2] == 1'b0 && rvalid;
  endproperty
  a_cfg_clear_reads_zero: assert property (p_cfg_clear_reads_zero) else $error("clear bit read back set");

  property p_mask_write;
    @(posedge aclk) disable iff (!aresetn) wr_mask |=> mask_reg == $past(wbyte_reg)
      ##1 source_mask == $past(wbyte_reg, 2);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_clear_pulse;
    @(posedge aclk) disable iff (!aresetn) wr_cfg && wbyte_reg[fault_flag_pkg::CFG_CLEAR_BIT]
      |=> clear_reg ##1 (!clear_reg || wr_cfg);
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong length");

endmodule : fault_event_flag_readback

// ==== verif/fault_event_flag_readback_tb.sv ====
// Self-checking bench for the fault and event flag readback block.
// Assumes the block answers on AXI4-Lite and samples event inputs through two flops.
`timescale 1ns/1ps

module fault_event_flag_readback_tb;

  // ****************************************
  // Signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic power_down_in = 1'b0, mic_clk_err_in = 1'b0, serial2_clk_err_in = 1'b0;
  logic [7:0] limiter_fault_src = 8'h00, clock_supply_src = 8'h00;
  logic load_diag_done_in = 1'b0;
  logic [1:0] load_diag_fault_in = 2'h0;
  logic [2:0] brownout_src = 3'h0;
  logic [7:0] source_mask, int_clk_cfg;
  int error_cnt = 0;
  int cmp_count = 0;
  // Short name for the OKAY response keeps the checking lines readable
  localparam logic [1:0] OKAY = fault_flag_pkg::RESP_OKAY;

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  fault_event_flag_readback dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .power_down_in(power_down_in), .mic_clk_err_in(mic_clk_err_in),
    .serial2_clk_err_in(serial2_clk_err_in), .limiter_fault_src(limiter_fault_src),
    .load_diag_done_in(load_diag_done_in), .load_diag_fault_in(load_diag_fault_in),
    .brownout_src(brownout_src), .clock_supply_src(clock_supply_src),
    .source_mask(source_mask), .int_clk_cfg(int_clk_cfg)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Byte address is four times the register index
  function automatic logic [7:0] baddr(input logic [7:0] idx);
    baddr = {idx[5:0], 2'b00};
  endfunction : baddr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cycles(input int k);
    repeat (k) @(posedge aclk);
  endtask : cycles

  // Address and data offered together; the loop bound stops a hung handshake
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] data, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= baddr(idx);
    wvalid <= 1'b1;
    wdata <= data;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (n >= 50) check(32'h1, 32'h0, "write handshake");
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= baddr(idx);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (n >= 50) check(32'h1, 32'h0, "read handshake");
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(idx, d, r);
    check(d, {24'h0, exp}, "read data");
    check({30'h0, r}, {30'h0, exp_resp}, "read response");
  endtask : rd_chk

  // Latch clear keeps the configuration at its reset value with the clear bit raised
  task automatic clear_latches();
    logic [1:0] r;
    axi_write(fault_flag_pkg::IDX_INT_CLK_CFG, {24'h0, fault_flag_pkg::CFG_RESET | 8'h04}, r);
    cycles(2);
  endtask : clear_latches

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, read-only readback, unmapped access and mask write
  task automatic t_regs();
    logic [1:0] r;
    rd_chk(fault_flag_pkg::IDX_LIVE, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LATCH_LIMITER, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LATCH_DIAG, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LATCH_CLOCK, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_SOURCE_MASK, 8'hFF, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_INT_CLK_CFG, 8'h19, fault_flag_pkg::RESP_OKAY);
    axi_write(fault_flag_pkg::IDX_LATCH_LIMITER, 32'hFF, r);
    check({30'h0, r}, {30'h0, OKAY}, "readback write response");
    axi_write(fault_flag_pkg::IDX_LIVE, 32'hFF, r);
    rd_chk(fault_flag_pkg::IDX_LATCH_LIMITER, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LIVE, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(8'h23, 8'h00, fault_flag_pkg::RESP_SLVERR);
    axi_write(8'h23, 32'h55, r);
    check({30'h0, r}, {30'h0, fault_flag_pkg::RESP_SLVERR}, "unmapped write");
    axi_write(fault_flag_pkg::IDX_SOURCE_MASK, 32'h7F, r);
    check({24'h0, source_mask}, 32'h7F, "mask port");
    rd_chk(fault_flag_pkg::IDX_SOURCE_MASK, 8'h7F, fault_flag_pkg::RESP_OKAY);
  endtask : t_regs

  // Every combination of the three live sources, reserved bits stay zero
  task automatic t_live();
    for (int p = 0; p < 8; p++) begin
      @(posedge aclk);
      {power_down_in, mic_clk_err_in, serial2_clk_err_in} <= p[2:0];
      cycles(4);
      rd_chk(fault_flag_pkg::IDX_LIVE, {p[2], 2'b00, p[1], p[0], 3'b000}, OKAY);
    end
    @(posedge aclk);
    {power_down_in, mic_clk_err_in, serial2_clk_err_in} <= 3'b000;
    cycles(4);
    rd_chk(fault_flag_pkg::IDX_LIVE, 8'h00, fault_flag_pkg::RESP_OKAY);
  endtask : t_live

  // Short events on each bit accumulate and stay after the sources drop
  task automatic t_latched();
    logic [7:0] acc;
    logic [7:0] acc_clk;
    acc = 8'h00;
    acc_clk = 8'h00;
    for (int n = 0; n < 8; n++) begin
      @(posedge aclk);
      limiter_fault_src <= 8'h01 << n;
      clock_supply_src <= 8'h80 >> n;
      if (n < 3) brownout_src <= 3'h1 << n;
      cycles(3);
      limiter_fault_src <= 8'h00;
      clock_supply_src <= 8'h00;
      brownout_src <= 3'h0;
      cycles(4);
      acc = acc | (8'h01 << n);
      acc_clk = acc_clk | (8'h80 >> n);
      rd_chk(fault_flag_pkg::IDX_LATCH_LIMITER, acc, OKAY);
      rd_chk(fault_flag_pkg::IDX_LATCH_CLOCK, acc_clk, OKAY);
    end
    rd_chk(fault_flag_pkg::IDX_LATCH_DIAG, 8'h07, fault_flag_pkg::RESP_OKAY);
    // Source still high across the clear keeps its flag set
    @(posedge aclk);
    limiter_fault_src <= 8'h10;
    cycles(4);
    clear_latches();
    rd_chk(fault_flag_pkg::IDX_LATCH_LIMITER, 8'h10, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LATCH_CLOCK, 8'h00, fault_flag_pkg::RESP_OKAY);
    rd_chk(fault_flag_pkg::IDX_LATCH_DIAG, 8'h00, fault_flag_pkg::RESP_OKAY);
    check({24'h0, int_clk_cfg}, 32'h19, "config port");
    limiter_fault_src <= 8'h00;
    cycles(4);
    clear_latches();
    rd_chk(fault_flag_pkg::IDX_LATCH_LIMITER, 8'h00, fault_flag_pkg::RESP_OKAY);
  endtask : t_latched

  // Each load result code is captured with completion and cleared together
  task automatic t_diag();
    logic [1:0] codes [3];
    codes = '{fault_flag_pkg::DIAG_NORMAL, fault_flag_pkg::DIAG_OPEN, fault_flag_pkg::DIAG_SHORT};
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      load_diag_fault_in <= codes[i];
      load_diag_done_in <= 1'b1;
      cycles(3);
      load_diag_done_in <= 1'b0;
      load_diag_fault_in <= 2'h0;
      cycles(4);
      rd_chk(fault_flag_pkg::IDX_LATCH_DIAG, {2'b00, 1'b1, codes[i], 3'b000}, OKAY);
      clear_latches();
      rd_chk(fault_flag_pkg::IDX_LATCH_DIAG, 8'h00, fault_flag_pkg::RESP_OKAY);
    end
  endtask : t_diag

  // ****************************************
  // Main sequence and verdict
  // ****************************************
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Reset is held for two edges so the input synchronisers flush to zero
  initial begin
    cycles(2);
    aresetn <= 1'b1;
    cycles(1);
    t_regs();
    t_live();
    t_latched();
    t_diag();
    conclude();
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

endmodule : fault_event_flag_readback_tb
